/* fanout_ctrl_pkg.sv */
package fanout_ctrl_pkg;

    // Output count and the group steered by the dedicated enable pins
    localparam int NUM_OUTPUTS      = 20;
    localparam int PIN_CTRL_LOW     = 5;
    localparam int PIN_CTRL_HIGH    = 12;
    localparam int NUM_OE_PINS      = PIN_CTRL_HIGH - PIN_CTRL_LOW + 1;

    // Register bus geometry
    localparam int ADDR_W           = 3;
    localparam int DATA_W           = 8;

    // Register offsets
    localparam logic [2:0] OFS_OE_HIGH     = 3'h0;
    localparam logic [2:0] OFS_OE_LOW      = 3'h1;
    localparam logic [2:0] OFS_OE_MID      = 3'h2;
    localparam logic [2:0] OFS_PIN_RDBACK  = 3'h3;
    localparam logic [2:0] OFS_RESERVED    = 3'h4;
    localparam logic [2:0] OFS_VENDOR_REV  = 3'h5;
    localparam logic [2:0] OFS_DEVICE_ID   = 3'h6;
    localparam logic [2:0] OFS_BYTE_COUNT  = 3'h7;

    // Field positions
    localparam int OE_HIGH_FIELD_LSB = 3;
    localparam int OE_HIGH_FIELD_W   = 4;
    localparam int OE_HIGH_OUT_LSB   = 16;
    localparam int OE_MID_OUT_LSB    = 8;
    localparam int BYTE_COUNT_W      = 6;

    // Reset values
    localparam logic [19:0] OE_RESET         = 20'hfffff;
    localparam logic [5:0]  BYTE_COUNT_RESET = 6'h08;

    // Timing, in output clock periods
    localparam int         SYNC_STAGES       = 2;
    localparam int         ENABLE_MAX_PERIODS = 10;
    localparam logic [2:0] STOP_MIN_CLOCKS   = 3'h4;

    // Tri-level select codes
    localparam logic [1:0] TRI_LOW  = 2'h0;
    localparam logic [1:0] TRI_MID  = 2'h1;
    localparam logic [1:0] TRI_HIGH = 2'h2;

endpackage

/* fanout_output_enable_power_down.sv */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module fanout_output_enable_power_down
    import fanout_ctrl_pkg::*;
#(
    parameter logic [7:0] VENDOR_REV = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_ID  = 8'ha5  // Arbitrary value
) (
    input  wire  logic                   ref_clk,
    input  wire  logic                   rst_b,
    input  wire  logic                   power_good_power_down_pin,
    input  wire  logic [NUM_OE_PINS-1:0] output_enable_pin_n,
    input  wire  logic [1:0]             address_select_low,
    input  wire  logic [1:0]             address_select_high,
    input  wire  logic [ADDR_W-1:0]      reg_addr,
    input  wire  logic [DATA_W-1:0]      reg_wdata,
    input  wire  logic                   reg_wr,
    input  wire  logic                   reg_rd,
    output logic       [DATA_W-1:0]      reg_rdata,
    output logic       [NUM_OUTPUTS-1:0] fanout_output_clock_gate,
    output logic       [1:0]             address_select_low_latched,
    output logic       [1:0]             address_select_high_latched,
    output logic                         config_captured,
    output logic                         power_save
);

    // Synchroniser stages; first stage feeds only the second
    logic                   pd_meta_r;
    logic                   pd_sync_r;
    logic [NUM_OE_PINS-1:0] oe_pin_meta_r;
    logic [NUM_OE_PINS-1:0] oe_pin_sync_r;
    logic [3:0]             sel_meta_r;
    logic [3:0]             sel_sync_r;

    // Software state
    logic [NUM_OUTPUTS-1:0]  oe_reg_r;
    logic [BYTE_COUNT_W-1:0] byte_count_r;
    logic [DATA_W-1:0]       rd_nxt;

    // Gating state
    logic [NUM_OUTPUTS-1:0] want_on;
    logic [NUM_OUTPUTS-1:0] gate_r;
    logic [2:0]             hold_cnt_r [NUM_OUTPUTS];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_meta_r <= 1'b0;
            pd_sync_r <= 1'b0;
        end else begin
            pd_meta_r <= power_good_power_down_pin;
            pd_sync_r <= pd_meta_r;
        end
    end

    // Pins idle high (disabled) until sampled
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_pin_meta_r <= '1;
            oe_pin_sync_r <= '1;
        end else begin
            oe_pin_meta_r <= output_enable_pin_n;
            oe_pin_sync_r <= oe_pin_meta_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_meta_r <= '0;
            sel_sync_r <= '0;
        end else begin
            sel_meta_r <= {address_select_high, address_select_low};
            sel_sync_r <= sel_meta_r;
        end
    end

    // Straps caught once, on the first power-good; later lows are power down
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            config_captured             <= 1'b0;
            address_select_low_latched  <= TRI_MID;
            address_select_high_latched <= TRI_MID;
        end else if (!config_captured && pd_sync_r) begin
            config_captured             <= 1'b1;
            address_select_low_latched  <= sel_sync_r[1:0];
            address_select_high_latched <= sel_sync_r[3:2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_save <= 1'b0;
        end else begin
            power_save <= config_captured && !pd_sync_r;
        end
    end

    // Register writes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_reg_r     <= OE_RESET;
            byte_count_r <= BYTE_COUNT_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_OE_HIGH: begin
                    oe_reg_r[OE_HIGH_OUT_LSB +: OE_HIGH_FIELD_W] <=
                        reg_wdata[OE_HIGH_FIELD_LSB +: OE_HIGH_FIELD_W];
                end
                OFS_OE_LOW: begin
                    oe_reg_r[DATA_W-1:0] <= reg_wdata;
                end
                OFS_OE_MID: begin
                    oe_reg_r[OE_MID_OUT_LSB +: DATA_W] <= reg_wdata;
                end
                OFS_BYTE_COUNT: begin
                    byte_count_r <= reg_wdata[BYTE_COUNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; read-only and reserved offsets ignore writes
    always_comb begin
        rd_nxt = '0;
        case (reg_addr)
            OFS_OE_HIGH: begin
                rd_nxt[OE_HIGH_FIELD_LSB +: OE_HIGH_FIELD_W] =
                    oe_reg_r[OE_HIGH_OUT_LSB +: OE_HIGH_FIELD_W];
            end
            OFS_OE_LOW:     rd_nxt = oe_reg_r[DATA_W-1:0];
            OFS_OE_MID:     rd_nxt = oe_reg_r[OE_MID_OUT_LSB +: DATA_W];
            OFS_PIN_RDBACK: rd_nxt = oe_pin_sync_r;
            OFS_RESERVED:   rd_nxt = '0;
            OFS_VENDOR_REV: rd_nxt = VENDOR_REV;
            OFS_DEVICE_ID:  rd_nxt = DEVICE_ID;
            OFS_BYTE_COUNT: rd_nxt = {{(DATA_W-BYTE_COUNT_W){1'b0}}, byte_count_r};
            default:        rd_nxt = '0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Wanted state of each output from register and power-good, and from the pins for outputs 5 to 12
    always_comb begin
        for (int i = 0; i < NUM_OUTPUTS; i++) begin
            if (i >= PIN_CTRL_LOW && i <= PIN_CTRL_HIGH) begin
                want_on[i] = pd_sync_r && oe_reg_r[i]
                             && !oe_pin_sync_r[i-PIN_CTRL_LOW];
            end else begin
                want_on[i] = pd_sync_r && oe_reg_r[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_out
            // Counts the clocks still owed after the enable goes away
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    hold_cnt_r[g] <= '0;
                end else if (want_on[g] || !gate_r[g]) begin
                    hold_cnt_r[g] <= STOP_MIN_CLOCKS;
                end else if (hold_cnt_r[g] != 3'h0) begin
                    hold_cnt_r[g] <= hold_cnt_r[g] - 3'h1;
                end
            end

            // Falling edge: clock is low, so no gate change cuts a pulse
            always_ff @(negedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    gate_r[g] <= 1'b0;
                end else if (!pd_sync_r) begin
                    gate_r[g] <= 1'b0;
                end else if (want_on[g]) begin
                    gate_r[g] <= 1'b1;
                end else if (hold_cnt_r[g] == 3'h0) begin
                    gate_r[g] <= 1'b0;
                end
            end

            sequence s_enable_dropped;
                $fell(want_on[g]) && pd_sync_r && gate_r[g];
            endsequence

            sequence s_still_running;
                (gate_r[g] || !pd_sync_r) [*3];
            endsequence

            AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
                s_enable_dropped |-> ##1 s_still_running)
                else $error("output stopped before four clocks");

            AST_STOP_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b)
                $fell(want_on[g]) |-> ##[1:7] (!gate_r[g] || want_on[g]))
                else $error("output not disabled in time");

            AST_START_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b)
                $rose(want_on[g]) |-> ##1 (gate_r[g] || !want_on[g]))
                else $error("output not resumed in time");
        end
    endgenerate

    // Gate flops run on the falling edge; the port copy keeps outputs flop driven
    assign fanout_output_clock_gate = gate_r;

    AST_PD_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(pd_sync_r) |-> ##1 (gate_r == '0))
        else $error("outputs alive after power down");

    AST_PG_LOW_ALL_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !pd_sync_r [*2] |-> (gate_r == '0))
        else $error("output running with power-good low");

    AST_PIN_BLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (oe_pin_sync_r[0] [*8]) |-> !gate_r[PIN_CTRL_LOW])
        else $error("pin disabled output still running");

    AST_PIN_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (pd_sync_r && oe_reg_r[0]) [*2] |-> gate_r[0])
        else $error("register-only output not running");

    AST_CFG_FROZEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        config_captured |=> $stable({address_select_high_latched,
                                     address_select_low_latched}))
        else $error("address select changed after capture");

    AST_CFG_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!config_captured && pd_sync_r) |=> (config_captured
            && address_select_low_latched == $past(sel_sync_r[1:0])))
        else $error("address select not captured");

    AST_PWR_SAVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (config_captured && !pd_sync_r) |=> power_save)
        else $error("power save not entered");

    AST_RDBACK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_PIN_RDBACK) |=> (reg_rdata == $past(oe_pin_sync_r)))
        else $error("pin readback wrong");

    AST_OE_RESET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(rst_b) |-> (oe_reg_r == OE_RESET))
        else $error("enable bits not set after reset");

    AST_REG_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!oe_reg_r[19]) [*8] |-> !gate_r[19])
        else $error("register disabled output running");

    // Register port: data only in the cycle after a read strobe
    AST_RD_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_OE_LOW) |=> (reg_rdata == $past(oe_reg_r[7:0])))
        else $error("low enable byte read wrong");

    AST_RD_MID: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_OE_MID) |=> (reg_rdata == $past(oe_reg_r[15:8])))
        else $error("middle enable byte read wrong");

    AST_RD_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_OE_HIGH)
            |=> (reg_rdata == {1'b0, $past(oe_reg_r[19:16]), 3'b000}))
        else $error("high enable byte read wrong");

    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !reg_rd |=> (reg_rdata == '0))
        else $error("read data left standing");

    AST_RD_RESERVED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_RESERVED) |=> (reg_rdata == '0))
        else $error("reserved byte not zero");

    AST_WR_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == OFS_OE_LOW) |=> (oe_reg_r[7:0] == $past(reg_wdata)))
        else $error("low enable byte not written");

    AST_WR_MID: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == OFS_OE_MID) |=> (oe_reg_r[15:8] == $past(reg_wdata)))
        else $error("middle enable byte not written");

    AST_WR_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == OFS_OE_HIGH) |=> (oe_reg_r[19:16] == $past(reg_wdata[6:3])))
        else $error("high enable field not written");

    // Readback byte is read only; a stray write must not touch enables
    AST_RDBACK_NO_WR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == OFS_PIN_RDBACK) |=> $stable(oe_reg_r))
        else $error("readback write changed enables");

    // Gating against power-good, register bits and pins
    AST_GATE_NEEDS_PG: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (gate_r != '0) |-> pd_sync_r)
        else $error("output running without power-good");

    AST_REG_BLOCKS_PIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!oe_reg_r[PIN_CTRL_LOW]) [*8] |-> !gate_r[PIN_CTRL_LOW])
        else $error("register bit ignored on pin output");

    AST_PIN_RUN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (pd_sync_r && oe_reg_r[PIN_CTRL_LOW] && !oe_pin_sync_r[0]) [*2]
            |-> gate_r[PIN_CTRL_LOW])
        else $error("enabled pin output not running");

    AST_TOP_IGNORES_PIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (pd_sync_r && oe_reg_r[19]) [*2] |-> gate_r[19])
        else $error("upper output not running");

    AST_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ($rose(pd_sync_r) && oe_reg_r[0]) |=> gate_r[0])
        else $error("output not restarted after power down");

    AST_SAVE_EXIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pd_sync_r |=> !power_save)
        else $error("power save kept with power-good high");

    AST_SAVE_NEEDS_CAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !config_captured |=> !power_save)
        else $error("power save before first power-good");

    // Straps are caught once; a later power cycle must not retake them
    AST_CFG_STAYS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        config_captured |=> config_captured)
        else $error("capture flag dropped");

    AST_SEL_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !config_captured |-> (address_select_low_latched == TRI_MID
            && address_select_high_latched == TRI_MID))
        else $error("address select taken before power-good");

endmodule

/* pin_ctrl_model.sv */
`timescale 1ns/1ps
module pin_ctrl_model
    import fanout_ctrl_pkg::*;
(
    input  wire logic                   clk_src,
    input  wire logic                   req_power,
    input  wire logic                   req_run,
    input  wire logic [NUM_OE_PINS-1:0] req_pin_n,
    output wire logic                   ref_clk,
    output wire logic                   pwr_pin,
    output wire logic [NUM_OE_PINS-1:0] oe_pin_n
);
    logic run_r = 1'b1;

    // Pins move off the clock grid, as a board drives them
    assign #7 oe_pin_n = req_pin_n;
    // Power pin drops with the stop request, well ahead of the clock
    assign #13 pwr_pin = req_power & req_run;
    assign ref_clk = clk_src & run_r;

    // Stop only while low, so no runt edge reaches the block
    always @(negedge req_run) begin
        repeat (4) @(negedge clk_src);
        run_r = 1'b0;
    end
    always @(posedge req_run) begin
        run_r = 1'b1;
    end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb import fanout_ctrl_pkg::*; ;
    logic                   clk_src = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   req_power = 1'b0;
    logic                   req_run = 1'b1;
    logic [NUM_OE_PINS-1:0] req_pin_n = '0;
    logic [1:0]             sel_lo = TRI_HIGH;
    logic [1:0]             sel_hi = TRI_LOW;
    logic [ADDR_W-1:0]      reg_addr = '0;
    logic [DATA_W-1:0]      reg_wdata = '0;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic                   ref_clk;
    logic                   pwr_pin;
    logic                   cap;
    logic                   psave;
    logic [NUM_OE_PINS-1:0] oe_n;
    logic [DATA_W-1:0]      rdata;
    logic [NUM_OUTPUTS-1:0] gate;
    logic [1:0]             lo_l;
    logic [1:0]             hi_l;
    int                     fail_count = 0;
    int                     n_tests = 0;
    int                     k;

    always #25 clk_src = ~clk_src;

    pin_ctrl_model pin_ctrl_model_i (.clk_src(clk_src), .req_power(req_power),
        .req_run(req_run), .req_pin_n(req_pin_n), .ref_clk(ref_clk),
        .pwr_pin(pwr_pin), .oe_pin_n(oe_n));

    fanout_output_enable_power_down fanout_output_enable_power_down_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .power_good_power_down_pin(pwr_pin),
        .output_enable_pin_n(oe_n), .address_select_low(sel_lo),
        .address_select_high(sel_hi), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .fanout_output_clock_gate(gate), .address_select_low_latched(lo_l),
        .address_select_high_latched(hi_l), .config_captured(cap),
        .power_save(psave));

    task automatic test_done();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    task automatic wait_gate(input int idx, input logic val);
        k = 0;
        while (gate[idx] !== val && k < 12) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic t_reset();
        cyc(1);
        chk("gate", gate, '0);
        chk("captured", cap, 1'b0);
        chk("sel", {lo_l, hi_l}, {TRI_MID, TRI_MID});
        rd(OFS_OE_HIGH, 8'h78);
        rd(OFS_OE_LOW, 8'hff);
        rd(OFS_OE_MID, 8'hff);
        rd(OFS_RESERVED, 8'h00);
    endtask

    task automatic t_power_up();
        @(posedge ref_clk);
        req_power <= 1'b1;
        cyc(8);
        chk("sel", {lo_l, hi_l}, {TRI_HIGH, TRI_LOW});
        chk("captured", cap, 1'b1);
        chk("gate", gate, 20'hfffff);
        sel_lo <= TRI_MID;
    endtask

    task automatic t_reg_gate();
        wr(OFS_OE_LOW, 8'hde);
        wr(OFS_OE_HIGH, 8'hf7);
        wr(OFS_PIN_RDBACK, 8'h55);
        cyc(12);
        chk("gate", gate, 20'heffde);
        rd(OFS_OE_HIGH, 8'h70);
        rd(OFS_PIN_RDBACK, 8'h00);
        wr(OFS_OE_LOW, 8'hff);
        wr(OFS_OE_HIGH, 8'h78);
        cyc(12);
        chk("gate", gate, 20'hfffff);
    endtask

    task automatic t_pin();
        @(posedge ref_clk);
        req_pin_n <= 8'h04;
        wait_gate(7, 1'b0);
        chk("stop_early", k >= 5, 1'b1);
        chk("stop_late", k <= 10, 1'b1);
        chk("gate", gate, 20'hfff7f);
        rd(OFS_PIN_RDBACK, 8'h04);
        @(posedge ref_clk);
        req_pin_n <= 8'h00;
        wait_gate(7, 1'b1);
        chk("start_late", k <= 10, 1'b1);
        @(posedge ref_clk);
        req_pin_n <= 8'hff;
        cyc(12);
        chk("gate", gate, 20'hfe01f);
        @(posedge ref_clk);
        req_pin_n <= 8'h00;
        cyc(12);
    endtask

    task automatic t_pdown();
        @(posedge ref_clk);
        req_power <= 1'b0;
        cyc(2);
        chk("gate", gate, 20'hfffff);
        cyc(1);
        chk("gate", gate, '0);
        chk("save", psave, 1'b1);
        wr(OFS_OE_LOW, 8'hfe);
        @(posedge ref_clk);
        req_power <= 1'b1;
        cyc(10);
        chk("gate", gate, 20'hffffe);
        chk("save", psave, 1'b0);
        chk("sel", {lo_l, hi_l}, {TRI_HIGH, TRI_LOW});
    endtask

    // The block clock halts here, so count on the free source
    task automatic t_clock_stop();
        @(posedge clk_src);
        req_run <= 1'b0;
        repeat (10) @(posedge clk_src);
        chk("gate", gate, '0);
        req_run <= 1'b1;
        repeat (12) @(posedge clk_src);
        #1;
        chk("gate", gate, 20'hffffe);
    endtask

    initial begin
        repeat (10) @(posedge clk_src);
        rst_b <= 1'b1;
        t_reset();
        t_power_up();
        t_reg_gate();
        t_pin();
        t_pdown();
        t_clock_stop();
        test_done();
    end

    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule
